// ===== hw/tcr_pkg.sv
package tcr_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] TCR_ADDR_CTRL   = 8'hC8;
  localparam logic [7:0] TCR_ADDR_CAP_LO = 8'hCA;
  localparam logic [7:0] TCR_ADDR_CAP_HI = 8'hCB;
  localparam logic [7:0] TCR_ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] TCR_ADDR_CNT_HI = 8'hCD;

  // control register field positions
  localparam int TCR_B_OVF   = 7;
  localparam int TCR_B_EXF   = 6;
  localparam int TCR_B_RCLK  = 5;
  localparam int TCR_B_TX_CLOCK_SELECT  = 4;
  localparam int TCR_B_EXEN  = 3;
  localparam int TCR_B_RUN   = 2;
  localparam int TCR_B_CTS   = 1;
  localparam int TCR_B_CPSEL = 0;

  // reset values and the counter maximum
  localparam logic [7:0]  TCR_CTRL_RST  = 8'h00;
  localparam logic [15:0] TCR_CNT_RST   = 16'h0000;
  localparam logic [15:0] TCR_CAP_RST   = 16'h0000;
  localparam logic [15:0] TCR_CNT_MAX   = 16'hFFFF;
  localparam logic [7:0]  TCR_RDATA_RST = 8'h00;

  // internal count rate is the oscillator divided by twelve
  localparam int         TCR_OSC_DIV  = 12;
  localparam int         TCR_DIV_W    = 4;
  localparam logic [3:0] TCR_DIV_LAST = 4'(TCR_OSC_DIV - 1);
  localparam logic [3:0] TCR_DIV_ZERO = 4'h0;

endpackage : tcr_pkg

// ===== hw/tcr_edge_sync.sv
`timescale 1ns/1ps
module tcr_edge_sync (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // pin side
  input  wire logic pin_i,
  // one-cycle pulse on a 1-to-0 transition
  output logic      fall_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first flop feeds only the second one
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      fall_o <= 1'b0;
    end else begin
      fall_o <= prev_r & ~sync_r;
    end
  end

endmodule : tcr_edge_sync

// ===== hw/tcr_timer.sv
// What this block does
// [RL1] counter is sixteen bits, a low and a high byte, timer or event counter
// [RL2] source select 0 counts clock divided by twelve, 1 counts count-pin falling edges
// [RL3] clock-select bits force baud mode, else capture or reload; run bit clear stops
// [RL4] capture mode, external enable clear: full 16-bit count, overflow flag on overflow
// [RL5] capture mode, external enable set: strobe falling edge copies count to capture regs
// [RL6] strobe-caused capture or reload with external enable sets the external-event flag
// [RL7] set external-event flag requests the timer interrupt; software clears it
// [RL8] reload mode: rollover sets overflow flag and reloads from capture/reload pair
// [RL9] reload mode with external enable: strobe falling edge also reloads, sets event flag
// [RL10] receive or transmit clock select, or both, give baud mode; rates may differ
// [RL11] baud mode: high byte rollover reloads whole counter from capture/reload pair
// [RL12] overflow flag set on overflow except in baud mode; software clears it
// [RL13] receive clock select routes this counter's overflow pulses to serial receive
// [RL14] transmit clock select routes this counter's overflow pulses to serial transmit
// [RL15] strobe ignored when external enable clear or when clocking the serial port
// [RL16] software runs it as a watchdog in reload mode with only run bit set
`timescale 1ns/1ps
module tcr_timer
  import tcr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // special function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // pins
  input  wire logic       count_pin_i,
  input  wire logic       strobe_input_i,
  // interrupt request and serial port ticks
  output logic            irq_req_o,
  output logic            rx_tick_o,
  output logic            tx_tick_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin edge detection

  logic cnt_fall;
  logic strobe_fall;

  tcr_edge_sync u_cnt_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (count_pin_i),
    .fall_o    (cnt_fall)
  );

  tcr_edge_sync u_strobe_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (strobe_input_i),
    .fall_o    (strobe_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [5:0]           ctrl_r;
  logic                 overflow_flag_r;
  logic                 external_event_flag_r;
  logic [15:0]          count_r;
  logic [15:0]          cap_r;
  logic [TCR_DIV_W-1:0] div_r;

  logic rx_clock_select;
  logic tx_clock_select;
  logic external_enable;
  logic run_bit;
  logic count_source_select;
  logic capture_reload_select;

  assign rx_clock_select       = ctrl_r[TCR_B_RCLK];
  assign tx_clock_select       = ctrl_r[TCR_B_TX_CLOCK_SELECT];
  assign external_enable       = ctrl_r[TCR_B_EXEN];
  assign run_bit               = ctrl_r[TCR_B_RUN];
  assign count_source_select   = ctrl_r[TCR_B_CTS];
  assign capture_reload_select = ctrl_r[TCR_B_CPSEL];

  logic wr_ctrl;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_cap_lo;
  logic wr_cap_hi;

  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == TCR_ADDR_CTRL);
  assign wr_cnt_lo = sfr_wr_i && (sfr_addr_i == TCR_ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr_i && (sfr_addr_i == TCR_ADDR_CNT_HI);
  assign wr_cap_lo = sfr_wr_i && (sfr_addr_i == TCR_ADDR_CAP_LO);
  assign wr_cap_hi = sfr_wr_i && (sfr_addr_i == TCR_ADDR_CAP_HI);

  //////////////////////////////////////////////////////////////////////////////
  // event decode

  logic div_tick;
  logic baud_mode;
  logic cnt_tick;
  logic ovf_evt;
  logic strobe_evt;

  assign div_tick   = (div_r == TCR_DIV_LAST);
  assign baud_mode  = rx_clock_select | tx_clock_select;                     // [RL3] [RL10]
  assign cnt_tick   = run_bit & (count_source_select ? cnt_fall : div_tick); // [RL2] [RL3]
  assign ovf_evt    = cnt_tick & (count_r == TCR_CNT_MAX);                   // [RL1]
  assign strobe_evt = strobe_fall & external_enable & ~baud_mode;            // [RL15]

  //////////////////////////////////////////////////////////////////////////////
  // prescaler, free running so the tick phase does not depend on the run bit

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      div_r <= TCR_DIV_ZERO;
    end else if (div_tick) begin
      div_r <= TCR_DIV_ZERO;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= TCR_CTRL_RST[5:0];
    end else if (wr_ctrl) begin
      ctrl_r <= sfr_wdata_i[5:0];
    end
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      overflow_flag_r <= TCR_CTRL_RST[TCR_B_OVF];
    end else if (ovf_evt && !baud_mode) begin
      overflow_flag_r <= 1'b1;                                              // [RL4] [RL8] [RL12]
    end else if (wr_ctrl) begin
      overflow_flag_r <= sfr_wdata_i[TCR_B_OVF];                            // [RL12]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      external_event_flag_r <= TCR_CTRL_RST[TCR_B_EXF];
    end else if (strobe_evt) begin
      external_event_flag_r <= 1'b1;                                        // [RL6] [RL9]
    end else if (wr_ctrl) begin
      external_event_flag_r <= sfr_wdata_i[TCR_B_EXF];                      // [RL7]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter; a software byte write beats a same-cycle count or reload

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      count_r <= TCR_CNT_RST;
    end else if (wr_cnt_lo) begin
      count_r[7:0] <= sfr_wdata_i;                                          // [RL1]
    end else if (wr_cnt_hi) begin
      count_r[15:8] <= sfr_wdata_i;                                         // [RL1]
    end else if (ovf_evt && (baud_mode || !capture_reload_select)) begin
      count_r <= cap_r;                                                     // [RL8] [RL11]
    end else if (strobe_evt && !capture_reload_select) begin
      count_r <= cap_r;                                                     // [RL9]
    end else if (cnt_tick) begin
      count_r <= count_r + 16'h0001;                                        // [RL4]
    end
  end

  // capture/reload pair
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cap_r <= TCR_CAP_RST;
    end else if (strobe_evt && capture_reload_select) begin
      cap_r <= count_r;                                                     // [RL5]
    end else if (wr_cap_lo) begin
      cap_r[7:0] <= sfr_wdata_i;
    end else if (wr_cap_hi) begin
      cap_r[15:8] <= sfr_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_tick_o <= 1'b0;
      tx_tick_o <= 1'b0;
    end else begin
      rx_tick_o <= ovf_evt & rx_clock_select;                               // [RL13]
      tx_tick_o <= ovf_evt & tx_clock_select;                               // [RL14]
    end
  end

  // the cpu interrupt enable lives outside; this is the raw request
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o <= overflow_flag_r | external_event_flag_r;                 // [RL7]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= TCR_RDATA_RST;
    end else begin
      unique case (sfr_addr_i)
        TCR_ADDR_CTRL:   sfr_rdata_o <= {overflow_flag_r, external_event_flag_r, ctrl_r};
        TCR_ADDR_CNT_LO: sfr_rdata_o <= count_r[7:0];
        TCR_ADDR_CNT_HI: sfr_rdata_o <= count_r[15:8];
        TCR_ADDR_CAP_LO: sfr_rdata_o <= cap_r[7:0];
        TCR_ADDR_CAP_HI: sfr_rdata_o <= cap_r[15:8];
        default:         sfr_rdata_o <= TCR_RDATA_RST;
      endcase
    end
  end

endmodule : tcr_timer

// ===== sim/tcr_pin_model.sv
`timescale 1ns/1ps
module tcr_pin_model (
  // clock
  input  wire logic ref_clk_i,
  // pins, idle high as if pulled up
  output logic      count_pin_o,
  output logic      strobe_o
);
  initial begin
    count_pin_o = 1'b1;
    strobe_o    = 1'b1;
  end
  ////////////////////////////////////////
  // low and high held 4 cycles each, above the 3-cycle sync need
  task automatic pulse(input bit strobe, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (strobe) strobe_o = 1'b0;
      else count_pin_o = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      strobe_o    = 1'b1;
      count_pin_o = 1'b1;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask : pulse
endmodule : tcr_pin_model

// ===== sim/tcr_timer_assertions.sv
`timescale 1ns/1ps
module tcr_timer_assertions
  import tcr_pkg::*;
(
  // clock, reset, register port
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // pins and outputs
  input wire logic       count_pin_i,
  input wire logic       strobe_input_i,
  input wire logic       irq_req_o,
  input wire logic       rx_tick_o,
  input wire logic       tx_tick_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic ctl_q;
  assign ctl_q = (sfr_addr_i == TCR_ADDR_CTRL) && !sfr_wr_i;
  ////////////////////////////////////////
  rst_out_a: assert property ($rose(rst_b_i) |-> sfr_rdata_o == 8'h00 && !irq_req_o)
    else $error("outputs not clear after reset");
  unmapped_rd_a: assert property (sfr_addr_i inside {8'hC9, 8'hCE} |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  wr_ctrl_a: assert property (sfr_wr_i && sfr_addr_i == TCR_ADDR_CTRL ##1 ctl_q
    |=> sfr_rdata_o[5:0] == $past(sfr_wdata_i[5:0], 2)) else $error("control write lost");
  irq_flag_a: assert property (ctl_q && $past(ctl_q) |-> irq_req_o == |sfr_rdata_o[7:6])
    else $error("irq does not follow flags");
  rx_pulse_a: assert property (rx_tick_o |=> !rx_tick_o [*5])
    else $error("rx tick too long");
  tx_pulse_a: assert property (tx_tick_o |=> !tx_tick_o [*5])
    else $error("tx tick too long");
  rx_off_a: assert property (ctl_q [*3] ##0 (!sfr_rdata_o[5] && !$past(sfr_rdata_o[5]))
    |-> !rx_tick_o) else $error("rx tick while not selected");
  tx_off_a: assert property (ctl_q [*3] ##0 (!sfr_rdata_o[4] && !$past(sfr_rdata_o[4]))
    |-> !tx_tick_o) else $error("tx tick while not selected");
  cover property (rx_tick_o && tx_tick_o);
  cover property ($rose(irq_req_o));
  cover property (tx_tick_o && !rx_tick_o);
endmodule : tcr_timer_assertions

// ===== sim/tb_tcr_timer.sv
`timescale 1ns/1ps
module tb_tcr_timer import tcr_pkg::*; ();
  logic       ref_clk_i, rst_b_i, sfr_wr_i, count_pin, strobe_pin;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic       irq_req_o, rx_tick_o, tx_tick_o;
  int         n_fail = 0, total_checks = 0, n_rx = 0, n_tx = 0;
  tcr_timer u_dut (.ref_clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .count_pin_i(count_pin), .strobe_input_i(strobe_pin), .irq_req_o, .rx_tick_o, .tx_tick_o);
  tcr_pin_model u_pin (.ref_clk_i, .count_pin_o(count_pin), .strobe_o(strobe_pin));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (rx_tick_o === 1'b1) n_rx <= n_rx + 1;
    if (tx_tick_o === 1'b1) n_tx <= n_tx + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(posedge ref_clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    #1;
    sfr_addr_i = a;
    @(posedge ref_clk_i);
    #1;
    chk(sfr_rdata_o, exp);
  endtask : rdc
  ////////////////////////////////////////
  task automatic t_reset;
    rdc(TCR_ADDR_CTRL, TCR_CTRL_RST);
    rdc(TCR_ADDR_CNT_LO, 8'h00);
    rdc(8'hC9, 8'h00);
  endtask : t_reset
  // external source keeps counts exact, no prescaler phase to guess
  task automatic t_capture;
    wr(TCR_ADDR_CTRL, 8'h0F);
    u_pin.pulse(0, 5);
    rdc(TCR_ADDR_CNT_LO, 8'h05);
    u_pin.pulse(1, 1);
    rdc(TCR_ADDR_CAP_LO, 8'h05);
    rdc(TCR_ADDR_CTRL, 8'h4F);
    chk({7'h00, irq_req_o}, 8'h01);
    wr(TCR_ADDR_CTRL, 8'h07);
    u_pin.pulse(1, 1);
    rdc(TCR_ADDR_CTRL, 8'h07);
    chk({7'h00, irq_req_o}, 8'h00);
  endtask : t_capture
  task automatic t_reload;
    wr(TCR_ADDR_CAP_HI, 8'h12);
    wr(TCR_ADDR_CAP_LO, 8'h34);
    wr(TCR_ADDR_CTRL, 8'h0E);
    u_pin.pulse(1, 1);
    rdc(TCR_ADDR_CNT_HI, 8'h12);
    rdc(TCR_ADDR_CTRL, 8'h4E);
  endtask : t_reload
  task automatic t_overflow;
    for (int m = 0; m < 2; m++) begin
      wr(TCR_ADDR_CTRL, 8'h06 | 8'(m));
      wr(TCR_ADDR_CNT_HI, 8'hFF);
      wr(TCR_ADDR_CNT_LO, 8'hFF);
      u_pin.pulse(0, 1);
      rdc(TCR_ADDR_CNT_HI, (m == 1) ? 8'h00 : 8'h12);
      rdc(TCR_ADDR_CNT_LO, (m == 1) ? 8'h00 : 8'h34);
      rdc(TCR_ADDR_CTRL, 8'h86 | 8'(m));
    end
  endtask : t_overflow
  task automatic t_baud;
    int         r, t;
    logic [7:0] sel;
    wr(TCR_ADDR_CAP_HI, 8'hFF);
    wr(TCR_ADDR_CAP_LO, 8'hFE);
    wr(TCR_ADDR_CNT_HI, 8'hFF);
    wr(TCR_ADDR_CNT_LO, 8'hFE);
    for (int k = 0; k < 2; k++) begin
      sel = (k == 0) ? 8'h36 : 8'h16;
      wr(TCR_ADDR_CTRL, sel);
      r = n_rx;
      t = n_tx;
      u_pin.pulse(0, 4);
      chk(8'(n_rx - r), (k == 0) ? 8'h02 : 8'h00);
      chk(8'(n_tx - t), 8'h02);
      rdc(TCR_ADDR_CTRL, sel);
      rdc(TCR_ADDR_CNT_LO, 8'hFE);
    end
    wr(TCR_ADDR_CTRL, 8'h3E);
    u_pin.pulse(1, 1);
    rdc(TCR_ADDR_CTRL, 8'h3E);
  endtask : t_baud
  // watchdog set-up: reload mode, internal source, only the run bit set
  task automatic t_watchdog;
    wr(TCR_ADDR_CAP_HI, 8'h12);
    wr(TCR_ADDR_CAP_LO, 8'h30);
    wr(TCR_ADDR_CNT_HI, 8'hFF);
    wr(TCR_ADDR_CNT_LO, 8'hFE);
    wr(TCR_ADDR_CTRL, 8'h04);
    // 120 edges of run time hold exactly ten prescaler ticks, whatever the phase
    repeat (116) @(posedge ref_clk_i);
    rdc(TCR_ADDR_CTRL, 8'h84);
    wr(TCR_ADDR_CTRL, 8'h80);
    // idle time would show up in the count if the cleared run bit failed to stop it
    repeat (24) @(posedge ref_clk_i);
    rdc(TCR_ADDR_CNT_LO, 8'h38);
    rdc(TCR_ADDR_CNT_HI, 8'h12);
    rdc(TCR_ADDR_CTRL, 8'h80);
    chk({7'h00, irq_req_o}, 8'h01);
  endtask : t_watchdog
  // reset again mid-run, with a flag set and the counter and pair loaded
  task automatic t_midreset;
    @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    t_reset();
    rdc(TCR_ADDR_CAP_HI, TCR_CAP_RST[15:8]);
    chk({7'h00, irq_req_o}, 8'h00);
  endtask : t_midreset
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    rst_b_i     = 1'b0;
    sfr_wr_i    = 1'b0;
    sfr_addr_i  = 8'h00;
    sfr_wdata_i = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    t_reset();
    t_capture();
    t_reload();
    t_overflow();
    t_baud();
    t_watchdog();
    t_midreset();
    complete_run();
  end
  // run is under 1000 cycles; 4000 gives ample margin
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
endmodule : tb_tcr_timer
bind tcr_timer tcr_timer_assertions u_chk (.ref_clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rdata_o, .count_pin_i, .strobe_input_i, .irq_req_o, .rx_tick_o, .tx_tick_o);
